//--- verilog/mfc_params.svh
// constants for the flow control unit: offsets, fields, resets, timing, frame layout
`ifndef MFC_PARAMS_SVH
`define MFC_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define MFC_OFS_FLOW_CONTROL 8'h00
`define MFC_OFS_ETH_CONTROL_ONE 8'h01
`define MFC_OFS_MAC_CONTROL_ONE 8'h02
`define MFC_OFS_BACK_TO_BACK_GAP 8'h03
`define MFC_OFS_PAUSE_VALUE_LOW 8'h04
`define MFC_OFS_PAUSE_VALUE_HIGH 8'h05
`define MFC_OFS_MAC_CONTROL_THREE 8'h06

// ****************************************
// field positions
// ****************************************
`define MFC_BIT_FLOW_ENABLE_LOW 0
`define MFC_BIT_FLOW_ENABLE_HIGH 1
`define MFC_BIT_DUPLEX_SHADOW 2
`define MFC_BIT_TRANSMIT_REQUEST 3
`define MFC_BIT_PASS_ALL_FRAMES 1
`define MFC_BIT_PAUSE_RECEIVE_ENABLE 2
`define MFC_BIT_PAUSE_TRANSMIT_ENABLE 3
`define MFC_BIT_MAC_FULL_DUPLEX 0

// ****************************************
// flow enable codes
// ****************************************
`define MFC_FC_OFF 2'h0
`define MFC_FC_ONCE 2'h1
`define MFC_FC_PERIODIC 2'h2
`define MFC_FC_ZERO_ONCE 2'h3

// ****************************************
// reset values
// ****************************************
`define MFC_RST_FLOW_ENABLE 2'h0
`define MFC_RST_GAP 7'h00
`define MFC_RST_PAUSE_VALUE 16'h0000
`define MFC_RST_BYTE 8'h00

// ****************************************
// timing
// ****************************************
`define MFC_CLK_PERIOD_NS 40
`define MFC_QUANTUM_NS 51200
`define MFC_QUANTUM_CYC (`MFC_QUANTUM_NS / `MFC_CLK_PERIOD_NS)

// ****************************************
// pause frame layout
// ****************************************
`define MFC_JAM_BYTE 8'h55
`define MFC_PAUSE_DEST 48'h0180C2000001
`define MFC_CTRL_TYPE 16'h8808
`define MFC_PAUSE_OPCODE 16'h0001
`define MFC_FCS_FIRST 6'h3C
`define MFC_FRAME_LAST 6'h3F
`define MFC_CRC_INIT 32'hFFFFFFFF
`define MFC_CRC_POLY 32'hEDB88320

`endif

//--- verilog/mfc_pkg.sv
// types of the flow control unit
package mfc_pkg;

    // ****************************************
    // transmit arbiter states
    // ****************************************
    typedef enum logic [2:0] {
        MFC_IDLE,
        MFC_JAM,
        MFC_GAP,
        MFC_HOST,
        MFC_PAUSE_TX
    } mfc_state_t;

    // ****************************************
    // pause timer state
    // ****************************************
    typedef struct packed {
        logic [15:0] count;
        logic [10:0] tick;
        logic running;
    } mfc_tmr_t;

    // ****************************************
    // top state
    // ****************************************
    typedef struct packed {
        mfc_state_t state;
        logic [1:0] flowEnable;
        logic transmitRequest;
        logic pauseTransmitEnable;
        logic pauseReceiveEnable;
        logic passAllFrames;
        logic macFullDuplex;
        logic [6:0] gapField;
        logic [15:0] pauseValue;
        logic [7:0] rdData;
        logic [7:0] lineData;
        logic lineValid;
        logic lineLast;
        logic hostTxGrant;
        logic [5:0] byteIdx;
        logic [31:0] crc;
        logic [15:0] frameValue;
        logic [6:0] gapCnt;
        logic sendPending;
        logic refreshRun;
    } mfc_top_t;

endpackage

//--- verilog/mfc_pause_timer.sv
// pause timer counting down once per 512 bit times
`timescale 1ns/1ns
`include "mfc_params.svh"

module mfc_pause_timer (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // load
    input wire logic loadEn,
    input wire logic [15:0] loadValue,
    // state
    output logic running
);

    mfc_pkg::mfc_tmr_t q;
    mfc_pkg::mfc_tmr_t d;

    always_comb begin
        d = q;
        if (loadEn) begin
            // a reload restarts the quantum so the new value counts whole
            d.count = loadValue;
            d.tick = 11'h000;
        end else if (q.count != 16'h0000) begin
            if (q.tick == 11'(`MFC_QUANTUM_CYC - 1)) begin
                d.tick = 11'h000;
                d.count = q.count - 16'h0001;
            end else begin
                d.tick = q.tick + 11'h001;
            end
        end else begin
            d.tick = 11'h000;
        end
        d.running = (d.count != 16'h0000);
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign running = q.running;

endmodule

//--- verilog/mfc_flow_control.sv
// flow control unit: half-duplex jamming and full-duplex pause frames
`timescale 1ns/1ns
`include "mfc_params.svh"

module mfc_flow_control (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    // station address
    input wire logic [47:0] stationAddr,
    // byte stream to the line
    output logic [7:0] lineData,
    output logic lineValid,
    output logic lineLast,
    input wire logic lineReady,
    // host packet path
    output logic hostTxGrant,
    input wire logic hostTxDone,
    input wire logic hostTxAbort,
    // received pause frames
    input wire logic rxPauseValid,
    input wire logic [15:0] rxPauseValue,
    // configuration to receive path
    output logic passAllFrames
);

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] mfcCrcByte(input logic [31:0] c, input logic [7:0] b);
        logic [31:0] r;
        r = c ^ {24'h000000, b};
        for (int i = 0; i < 8; i++) begin
            r = r[0] ? ((r >> 1) ^ `MFC_CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction

    function automatic logic [7:0] mfcFrameByte(input logic [5:0] idx, input logic [47:0] src,
                                                input logic [15:0] val, input logic [31:0] crc);
        logic [47:0] s;
        logic [31:0] f;
        logic [7:0] b;
        s = 48'h000000000000;
        f = ~crc;
        b = 8'h00;
        if (idx < 6'h06) begin
            s = `MFC_PAUSE_DEST << {idx, 3'b000};
            b = s[47:40];
        end else if (idx < 6'h0C) begin
            s = src << {idx - 6'h06, 3'b000};
            b = s[47:40];
        end else if (idx >= `MFC_FCS_FIRST) begin
            // frame check sequence goes out low byte first
            f = f >> {idx - `MFC_FCS_FIRST, 3'b000};
            b = f[7:0];
        end else begin
            case (idx)
                6'h0C: b = 8'(`MFC_CTRL_TYPE >> 8);
                6'h0D: b = 8'(`MFC_CTRL_TYPE);
                6'h0E: b = 8'(`MFC_PAUSE_OPCODE >> 8);
                6'h0F: b = 8'(`MFC_PAUSE_OPCODE);
                6'h10: b = val[15:8];
                6'h11: b = val[7:0];
                default: b = 8'h00;
            endcase
        end
        return b;
    endfunction

    // ****************************************
    // pause timers
    // ****************************************
    mfc_pkg::mfc_top_t q;
    mfc_pkg::mfc_top_t d;
    logic rxLoad;
    logic rxRunning;
    logic refreshLoad;
    logic [15:0] refreshValue;
    logic refreshRunning;
    logic transfer;
    logic frameDone;
    logic [31:0] crcNext;
    logic [5:0] idxNext;

    assign rxLoad = rxPauseValid && q.pauseReceiveEnable;

    mfc_pause_timer u_rx_timer (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .loadEn(rxLoad),
        .loadValue(rxPauseValue),
        .running(rxRunning)
    );

    // refresh at half the advertised time, or one quantum when that is zero, so the partner never wakes up for values of 2 and more
    assign refreshValue = (q.pauseValue[15:1] == 15'h0000) ? 16'h0001 : {1'b0, q.pauseValue[15:1]};

    mfc_pause_timer u_refresh_timer (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .loadEn(refreshLoad),
        .loadValue(refreshValue),
        .running(refreshRunning)
    );

    assign transfer = q.lineValid && lineReady;
    assign frameDone = (q.state == mfc_pkg::MFC_PAUSE_TX) && transfer && q.lineLast;
    assign refreshLoad = frameDone && q.macFullDuplex && (q.flowEnable == `MFC_FC_PERIODIC);
    assign idxNext = q.byteIdx + 6'h01;
    assign crcNext = (q.byteIdx < `MFC_FCS_FIRST) ? mfcCrcByte(q.crc, q.lineData) : q.crc;

    // ****************************************
    // next state
    // ****************************************
    always_comb begin
        d = q;
        d.rdData = 8'h00;
        d.refreshRun = refreshRunning;

        // periodic refresh expiry queues the next frame
        if (q.refreshRun && !refreshRunning && q.macFullDuplex && q.flowEnable == `MFC_FC_PERIODIC) begin
            d.sendPending = 1'b1;
        end

        case (q.state)
            mfc_pkg::MFC_IDLE: begin
                d.lineValid = 1'b0;
                d.lineLast = 1'b0;
                if (q.macFullDuplex) begin
                    if (q.sendPending && q.pauseTransmitEnable) begin
                        d.state = mfc_pkg::MFC_PAUSE_TX;
                        d.sendPending = 1'b0;
                        d.frameValue = (q.flowEnable == `MFC_FC_ZERO_ONCE) ? 16'h0000 : q.pauseValue;
                        d.byteIdx = 6'h00;
                        d.crc = `MFC_CRC_INIT;
                        d.lineData = mfcFrameByte(6'h00, stationAddr, d.frameValue, `MFC_CRC_INIT);
                        d.lineValid = 1'b1;
                    end else if (q.transmitRequest && !(rxRunning && q.pauseReceiveEnable)) begin
                        // a paused request just waits here until the timer runs out
                        d.state = mfc_pkg::MFC_HOST;
                        d.hostTxGrant = 1'b1;
                    end
                end else if (q.flowEnable[`MFC_BIT_FLOW_ENABLE_LOW]) begin
                    if (q.transmitRequest) begin
                        d.state = mfc_pkg::MFC_GAP;
                        d.gapCnt = q.gapField;
                    end else begin
                        d.state = mfc_pkg::MFC_JAM;
                        d.lineData = `MFC_JAM_BYTE;
                        d.lineValid = 1'b1;
                    end
                end else if (q.transmitRequest) begin
                    d.state = mfc_pkg::MFC_HOST;
                    d.hostTxGrant = 1'b1;
                end
            end
            mfc_pkg::MFC_JAM: begin
                if (q.macFullDuplex || !q.flowEnable[`MFC_BIT_FLOW_ENABLE_LOW]) begin
                    d.state = mfc_pkg::MFC_IDLE;
                    d.lineValid = 1'b0;
                end else if (q.transmitRequest) begin
                    d.state = mfc_pkg::MFC_GAP;
                    d.gapCnt = q.gapField;
                    d.lineValid = 1'b0;
                end else begin
                    d.lineData = `MFC_JAM_BYTE;
                    d.lineValid = 1'b1;
                end
            end
            mfc_pkg::MFC_GAP: begin
                if (q.gapCnt == 7'h00) begin
                    d.state = mfc_pkg::MFC_HOST;
                    d.hostTxGrant = 1'b1;
                end else begin
                    d.gapCnt = q.gapCnt - 7'h01;
                end
            end
            mfc_pkg::MFC_HOST: begin
                if (hostTxDone || hostTxAbort) begin
                    d.state = mfc_pkg::MFC_IDLE;
                    d.hostTxGrant = 1'b0;
                    d.transmitRequest = 1'b0;
                end
            end
            mfc_pkg::MFC_PAUSE_TX: begin
                if (transfer) begin
                    if (q.lineLast) begin
                        d.state = mfc_pkg::MFC_IDLE;
                        d.lineValid = 1'b0;
                        d.lineLast = 1'b0;
                        // one-shot codes fall back to off after their frame
                        if (q.flowEnable != `MFC_FC_PERIODIC) begin
                            d.flowEnable = `MFC_FC_OFF;
                        end
                    end else begin
                        d.byteIdx = idxNext;
                        d.crc = crcNext;
                        d.lineData = mfcFrameByte(idxNext, stationAddr, q.frameValue, crcNext);
                        d.lineLast = (idxNext == `MFC_FRAME_LAST);
                    end
                end
            end
            default: begin
                d.state = mfc_pkg::MFC_IDLE;
                d.lineValid = 1'b0;
                d.hostTxGrant = 1'b0;
            end
        endcase

        // software writes come last so a write beats the hardware update
        if (regWrEn) begin
            case (regAddr)
                `MFC_OFS_FLOW_CONTROL: begin
                    d.flowEnable = regWrData[`MFC_BIT_FLOW_ENABLE_HIGH:`MFC_BIT_FLOW_ENABLE_LOW];
                    d.sendPending = q.macFullDuplex && (d.flowEnable != `MFC_FC_OFF);
                end
                `MFC_OFS_ETH_CONTROL_ONE: begin
                    d.transmitRequest = regWrData[`MFC_BIT_TRANSMIT_REQUEST];
                end
                `MFC_OFS_MAC_CONTROL_ONE: begin
                    d.pauseTransmitEnable = regWrData[`MFC_BIT_PAUSE_TRANSMIT_ENABLE];
                    d.pauseReceiveEnable = regWrData[`MFC_BIT_PAUSE_RECEIVE_ENABLE];
                    d.passAllFrames = regWrData[`MFC_BIT_PASS_ALL_FRAMES];
                end
                `MFC_OFS_BACK_TO_BACK_GAP: begin
                    d.gapField = regWrData[6:0];
                end
                `MFC_OFS_PAUSE_VALUE_LOW: begin
                    d.pauseValue[7:0] = regWrData;
                end
                `MFC_OFS_PAUSE_VALUE_HIGH: begin
                    d.pauseValue[15:8] = regWrData;
                end
                `MFC_OFS_MAC_CONTROL_THREE: begin
                    d.macFullDuplex = regWrData[`MFC_BIT_MAC_FULL_DUPLEX];
                end
                default: begin
                end
            endcase
        end

        if (regRdEn) begin
            case (regAddr)
                `MFC_OFS_FLOW_CONTROL: d.rdData = {5'b00000, q.macFullDuplex, q.flowEnable};
                `MFC_OFS_ETH_CONTROL_ONE: d.rdData = {4'h0, q.transmitRequest, 3'b000};
                `MFC_OFS_MAC_CONTROL_ONE: d.rdData = {4'h0, q.pauseTransmitEnable, q.pauseReceiveEnable,
                                                      q.passAllFrames, 1'b0};
                `MFC_OFS_BACK_TO_BACK_GAP: d.rdData = {1'b0, q.gapField};
                `MFC_OFS_PAUSE_VALUE_LOW: d.rdData = q.pauseValue[7:0];
                `MFC_OFS_PAUSE_VALUE_HIGH: d.rdData = q.pauseValue[15:8];
                `MFC_OFS_MAC_CONTROL_THREE: d.rdData = {7'h00, q.macFullDuplex};
                default: d.rdData = 8'h00;
            endcase
        end
    end

    // ****************************************
    // state register
    // ****************************************
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
            q.state <= mfc_pkg::MFC_IDLE;
            q.flowEnable <= `MFC_RST_FLOW_ENABLE;
            q.gapField <= `MFC_RST_GAP;
            q.pauseValue <= `MFC_RST_PAUSE_VALUE;
            q.rdData <= `MFC_RST_BYTE;
            q.crc <= `MFC_CRC_INIT;
        end else begin
            q <= d;
        end
    end

    assign regRdData = q.rdData;
    assign lineData = q.lineData;
    assign lineValid = q.lineValid;
    assign lineLast = q.lineLast;
    assign hostTxGrant = q.hostTxGrant;
    assign passAllFrames = q.passAllFrames;

endmodule

//--- sim/mfc_flow_control_asserts.sv
// port checker for the flow control unit
`timescale 1ns/1ns
`include "mfc_params.svh"

module mfc_flow_control_asserts (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWrData,
    input wire logic regWrEn,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    // line, host, receive
    input wire logic [7:0] lineData,
    input wire logic lineValid,
    input wire logic lineLast,
    input wire logic lineReady,
    input wire logic hostTxGrant,
    input wire logic hostTxDone,
    input wire logic hostTxAbort,
    input wire logic rxPauseValid,
    input wire logic [15:0] rxPauseValue
);
    // ********
    // shadow of host settings
    // ********
    logic fd_q, jam_q, rxEn_q, arm_q;
    logic [6:0] gap_q;
    logic [8:0] since_q;
    logic [31:0] pause_q;
    wire reqWr = regWrEn && regAddr == `MFC_OFS_ETH_CONTROL_ONE && regWrData[3] && !fd_q && lineValid;
    wire wrFlow = regWrEn && regAddr == `MFC_OFS_FLOW_CONTROL;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            fd_q <= 1'b0;
            jam_q <= 1'b0;
            rxEn_q <= 1'b0;
            arm_q <= 1'b0;
            gap_q <= 7'h00;
            since_q <= 9'h000;
            pause_q <= 32'h0;
        end else begin
            if (regWrEn && regAddr == `MFC_OFS_MAC_CONTROL_THREE) fd_q <= regWrData[0];
            if (wrFlow) jam_q <= regWrData[0];
            if (regWrEn && regAddr == `MFC_OFS_MAC_CONTROL_ONE) rxEn_q <= regWrData[2];
            if (regWrEn && regAddr == `MFC_OFS_BACK_TO_BACK_GAP) gap_q <= regWrData[6:0];
            arm_q <= reqWr || (arm_q && !hostTxGrant);
            since_q <= reqWr ? 9'h000 : since_q + 9'h001;
            // margin of a few cycles: tick phase after load is not visible here
            if (rxPauseValid && rxEn_q) pause_q <= (rxPauseValue == 16'h0) ? 32'h0 :
                {16'h0, rxPauseValue} * 32'(`MFC_QUANTUM_CYC) - 32'h8;
            else if (pause_q != 32'h0) pause_q <= pause_q - 32'h1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    sequence grantEnds; !hostTxGrant; endsequence
    sequence jamBack; lineValid && lineData == `MFC_JAM_BYTE; endsequence

    AST_FLOW_PAD: assert property (regRdEn && regAddr == `MFC_OFS_FLOW_CONTROL |=> regRdData[7:3] == 5'h00)
        else $error("flow control upper bits set");
    AST_SHADOW: assert property (regRdEn && regAddr == `MFC_OFS_FLOW_CONTROL |=> regRdData[2] == fd_q)
        else $error("duplex shadow wrong");
    AST_JAM_DATA: assert property (lineValid && !fd_q |-> lineData == `MFC_JAM_BYTE)
        else $error("jam byte wrong");
    AST_GAP: assert property ($rose(hostTxGrant) && arm_q |-> since_q == {2'b00, gap_q} + 9'h002)
        else $error("gap length wrong");
    AST_RESUME: assert property ((hostTxDone || hostTxAbort) && hostTxGrant && !fd_q && jam_q |=> grantEnds ##1 jamBack)
        else $error("jam did not resume");
    AST_STOP: assert property (wrFlow && !regWrData[0] && !fd_q && lineValid |-> ##2 !lineValid [*4])
        else $error("jam did not stop");
    AST_LAST_HOLD: assert property (lineLast && !lineReady |=> lineLast && lineValid)
        else $error("last byte dropped");
    AST_LAST_END: assert property (lineValid && lineLast && lineReady |=> !lineValid)
        else $error("frame runs past last byte");
    AST_FD_START: assert property ($rose(lineValid) && fd_q |-> lineData == 8'h01)
        else $error("frame start byte wrong");
    AST_PAUSE_HOLD: assert property (rxPauseValid && rxEn_q && fd_q && rxPauseValue != 16'h0 && !hostTxGrant
        |=> !hostTxGrant [*8])
        else $error("grant while paused");
    AST_PAUSE_WAIT: assert property ($rose(hostTxGrant) && fd_q |-> pause_q == 32'h0)
        else $error("grant before pause expiry");
endmodule

bind mfc_flow_control mfc_flow_control_asserts chk_u (.ref_clk, .rstn, .regAddr, .regWrData, .regWrEn,
    .regRdEn, .regRdData, .lineData, .lineValid, .lineLast, .lineReady, .hostTxGrant, .hostTxDone,
    .hostTxAbort, .rxPauseValid, .rxPauseValue);

//--- sim/mfc_link_partner.sv
// link partner model: takes line bytes, reports received pause frames
`timescale 1ns/1ns

module mfc_link_partner (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // line from the unit
    input wire logic [7:0] lineData,
    input wire logic lineValid,
    input wire logic lineLast,
    output logic lineReady,
    // received pause
    output logic rxPauseValid,
    output logic [15:0] rxPauseValue,
    // pacing
    input wire logic slow
);
    logic [1:0] pace_q;
    logic [5:0] idx_q;
    logic [7:0] frameBuf [0:63];
    int frameCnt;

    // slow: one byte in three, so every byte after the first is held at least once
    assign lineReady = !slow || pace_q == 2'h2;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pace_q <= 2'h0;
            idx_q <= 6'h00;
            frameCnt <= 0;
        end else begin
            pace_q <= (pace_q == 2'h2) ? 2'h0 : pace_q + 2'h1;
            if (!lineValid) begin
                idx_q <= 6'h00;
            end else if (lineReady) begin
                frameBuf[idx_q] <= lineData;
                idx_q <= idx_q + 6'h01;
                if (lineLast) frameCnt <= frameCnt + 1;
            end
        end
    end

    initial begin
        rxPauseValid = 1'b0;
        rxPauseValue = 16'h0000;
    end

    // value inverted once the pulse is over, so a stale value never looks valid
    task automatic sendPause(input logic [15:0] v);
        @(posedge ref_clk);
        rxPauseValid <= 1'b1;
        rxPauseValue <= v;
        @(posedge ref_clk);
        rxPauseValid <= 1'b0;
        rxPauseValue <= ~v;
    endtask
endmodule

//--- sim/mfc_flow_control_tb_top.sv
// self-checking bench for the flow control unit
`timescale 1ns/1ns
`include "mfc_params.svh"

`define CHK(act, exp) begin checkCount++; if ((act) !== (exp)) begin mismatches++; \
    $display("FAIL t=%0t got=%h exp=%h", $time, act, exp); end end

module mfc_flow_control_tb_top;
    localparam logic [47:0] STATION = 48'h02A1B2C3D4E5;
    logic ref_clk, rstn, regWrEn, regRdEn, hostTxDone, hostTxAbort, slow;
    logic [7:0] regAddr, regWrData, regRdData, lineData;
    logic lineValid, lineLast, lineReady, hostTxGrant, rxPauseValid, passAllFrames;
    logic [15:0] rxPauseValue;
    int mismatches, checkCount, t0, n, fc;

    mfc_flow_control dut_u (.ref_clk, .rstn, .regAddr, .regWrData, .regWrEn, .regRdEn, .regRdData,
        .stationAddr(STATION), .lineData, .lineValid, .lineLast, .lineReady, .hostTxGrant, .hostTxDone,
        .hostTxAbort, .rxPauseValid, .rxPauseValue, .passAllFrames);
    mfc_link_partner link_u (.ref_clk, .rstn, .lineData, .lineValid, .lineLast, .lineReady, .rxPauseValid,
        .rxPauseValue, .slow);

    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end

    // ********
    // access tasks
    // ********
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge ref_clk);
        regWrEn <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge ref_clk);
        regRdEn <= 1'b0;
        @(posedge ref_clk);
        `CHK(regRdData, exp)
    endtask

    task automatic pulseDone(input logic abort);
        hostTxDone <= !abort;
        hostTxAbort <= abort;
        @(posedge ref_clk);
        hostTxDone <= 1'b0;
        hostTxAbort <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask

    task automatic waitGrant(input int lim);
        n = 0;
        while (hostTxGrant !== 1'b1 && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
    endtask

    task automatic waitFrame(input int lim);
        fc = link_u.frameCnt;
        t0 = 0;
        while (link_u.frameCnt == fc && t0 < lim) begin
            @(posedge ref_clk);
            t0++;
        end
        `CHK(t0 < lim, 1'b1)
    endtask

    task automatic chkFrame(input logic [15:0] v);
        logic [31:0] c;
        logic [7:0] e [0:63];
        e = '{default: 8'h00};
        for (int i = 0; i < 6; i++) begin
            e[i] = 8'(`MFC_PAUSE_DEST >> (40 - 8 * i));
            e[6 + i] = 8'(STATION >> (40 - 8 * i));
        end
        {e[12], e[13], e[14], e[15], e[16], e[17]} = {`MFC_CTRL_TYPE, `MFC_PAUSE_OPCODE, v};
        c = `MFC_CRC_INIT;
        for (int i = 0; i < 60; i++) begin
            c = c ^ {24'h000000, e[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ `MFC_CRC_POLY : c >> 1;
        end
        c = ~c;
        for (int i = 0; i < 4; i++) e[60 + i] = 8'(c >> (8 * i));
        for (int i = 0; i < 64; i++) `CHK(link_u.frameBuf[i], e[i])
    endtask

    task automatic finish_test();
        if (mismatches == 0 && checkCount > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // ********
    // watchdog and tests
    // ********
    initial begin
        repeat (40000) @(posedge ref_clk);
        mismatches++;
        finish_test();
    end

    initial begin
        rstn = 1'b0;
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
        hostTxDone = 1'b0;
        hostTxAbort = 1'b0;
        slow = 1'b1;
        repeat (5) @(posedge ref_clk);
        rstn <= 1'b1;
        @(posedge ref_clk);
        // reset values, 07 is unmapped
        for (int a = 0; a < 8; a++) rd(8'(a), 8'h00);
        wr(`MFC_OFS_PAUSE_VALUE_LOW, 8'hA5);
        wr(`MFC_OFS_PAUSE_VALUE_HIGH, 8'h3C);
        wr(`MFC_OFS_BACK_TO_BACK_GAP, 8'h05);
        rd(`MFC_OFS_PAUSE_VALUE_LOW, 8'hA5);
        rd(`MFC_OFS_PAUSE_VALUE_HIGH, 8'h3C);
        rd(`MFC_OFS_BACK_TO_BACK_GAP, 8'h05);
        // jamming only on this closed bench
        wr(`MFC_OFS_FLOW_CONTROL, 8'hFF);
        rd(`MFC_OFS_FLOW_CONTROL, 8'h03);
        `CHK({hostTxGrant, lineValid, lineData}, 10'h155)
        for (int k = 0; k < 2; k++) begin
            wr(`MFC_OFS_ETH_CONTROL_ONE, 8'h08);
            waitGrant(200);
            `CHK({hostTxGrant, lineValid}, 2'b10)
            pulseDone(k[0]);
            `CHK({hostTxGrant, lineValid, lineData}, 10'h155)
            rd(`MFC_OFS_ETH_CONTROL_ONE, 8'h00);
        end
        wr(`MFC_OFS_FLOW_CONTROL, 8'h02);
        repeat (2) @(posedge ref_clk);
        `CHK(lineValid, 1'b0)
        wr(`MFC_OFS_FLOW_CONTROL, 8'h00);
        // duplex set, then seen in the flow control shadow bit
        wr(`MFC_OFS_MAC_CONTROL_THREE, 8'h01);
        rd(`MFC_OFS_FLOW_CONTROL, 8'h04);
        wr(`MFC_OFS_MAC_CONTROL_ONE, 8'h0E);
        rd(`MFC_OFS_MAC_CONTROL_ONE, 8'h0E);
        `CHK(passAllFrames, 1'b1)
        wr(`MFC_OFS_FLOW_CONTROL, 8'h01);
        waitFrame(1000);
        chkFrame(16'h3CA5);
        rd(`MFC_OFS_FLOW_CONTROL, 8'h04);
        wr(`MFC_OFS_FLOW_CONTROL, 8'h03);
        waitFrame(1000);
        chkFrame(16'h0000);
        rd(`MFC_OFS_FLOW_CONTROL, 8'h04);
        // periodic frames with a host packet between them
        slow <= 1'b0;
        wr(`MFC_OFS_PAUSE_VALUE_LOW, 8'h02);
        wr(`MFC_OFS_PAUSE_VALUE_HIGH, 8'h00);
        wr(`MFC_OFS_FLOW_CONTROL, 8'h02);
        waitFrame(200);
        chkFrame(16'h0002);
        wr(`MFC_OFS_ETH_CONTROL_ONE, 8'h08);
        waitGrant(50);
        `CHK(hostTxGrant, 1'b1)
        pulseDone(1'b0);
        waitFrame(2400);
        chkFrame(16'h0002);
        wr(`MFC_OFS_FLOW_CONTROL, 8'h03);
        waitFrame(300);
        chkFrame(16'h0000);
        fc = link_u.frameCnt;
        repeat (1500) @(posedge ref_clk);
        `CHK(link_u.frameCnt == fc, 1'b1)
        // received pause, reloaded, then released by a zero value
        link_u.sendPause(16'h0003);
        repeat (1000) @(posedge ref_clk);
        link_u.sendPause(16'h0001);
        wr(`MFC_OFS_ETH_CONTROL_ONE, 8'h08);
        waitGrant(3000);
        `CHK(n > 1200 && n < 1300, 1'b1)
        pulseDone(1'b0);
        rd(`MFC_OFS_ETH_CONTROL_ONE, 8'h00);
        link_u.sendPause(16'h0005);
        wr(`MFC_OFS_ETH_CONTROL_ONE, 8'h08);
        repeat (100) @(posedge ref_clk);
        `CHK(hostTxGrant, 1'b0)
        link_u.sendPause(16'h0000);
        waitGrant(20);
        `CHK(hostTxGrant, 1'b1)
        pulseDone(1'b0);
        finish_test();
    end
endmodule
